/* File: ddr_bank_ctrl.sv */
`timescale 1ns/100ps
// Functional notes
// - first read word after read latency
// - precharge ends read after latency cycles
// - read auto precharge idles bank after burst
// - write words taken on both strobe edges
// - write auto precharge idles bank after burst
// - single precharge one bank; all hits active
// - precharge in write resets input path
// - burst stop ends reads, never writes
// - self refresh entry with idle banks
// - clock enable low enters power down
// - burst length code 2, 4, 8
// - order bit sequential or interleaved wrap
// - latency code 2 or 2.5
// - bank select picks mode or extended
// - extended bits dll off, half drive
// - dll reset bit; test, reserved zero
// - burst stop encoding, read only
module ddr_bank_ctrl #(
    parameter int REFRESH_CYCLES = ddr_pkg::REFRESH_INTERVAL_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic strobeClk,
    input wire logic cke,
    input wire logic csN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic bankSelectHigh,
    input wire logic bankSelectLow,
    input wire logic [12:0] addr,
    input wire logic [15:0] dqIn,
    input wire logic writeByteMask,
    input wire logic [15:0] arrayReadRise,
    input wire logic [15:0] arrayReadFall,
    output logic [15:0] readRiseWord,
    output logic [15:0] readFallWord,
    output logic dqDriveEn_n,
    output logic readHalfLate,
    output logic arrayReadEn,
    output logic arrayWriteEn,
    output logic [1:0] arrayBank,
    output logic [8:0] arrayColRise,
    output logic [8:0] arrayColFall,
    output logic [15:0] arrayWriteRise,
    output logic [15:0] arrayWriteFall,
    output logic [1:0] arrayWriteMask,
    output logic arrayRefresh,
    output logic [12:0] refreshRow,
    output logic [3:0] bankOpen,
    output logic selfRefreshOn,
    output logic powerDownOn,
    output logic ioBuffersOn,
    output logic dllOn,
    output logic halfDrive,
    output logic modeReady,
    output logic dllReset
);
    typedef enum logic [2:0] {B_IDLE = 3'h1, B_READ = 3'h2, B_WRITE = 3'h4} burst_t;
    typedef enum logic [2:0] {P_ON = 3'h1, P_DOWN = 3'h2, P_SELF = 3'h4} power_t;
    typedef struct packed {
        logic [1:0][22:0] pinSync; // two-stage pin synchroniser
        logic [1:0][1:0] ptrSync; // write pointer crossing
        logic [1:0] rdPtr; // next slot to drain
        burst_t burst;
        power_t power;
        logic [3:0] open; // banks with a row open
        logic [1:0] bBank; // burst bank
        logic [8:0] bCol; // burst start column
        logic bAuto; // auto precharge pending
        logic [2:0] pairsLeft; // beat pairs still due
        logic [1:0] pairIdx; // current pair in burst
        logic [1:0] rdWait; // latency countdown
        logic term; // read cut short
        logic [1:0] termCount; // cycles until drive stops
        logic prevCke;
        logic [12:0] row; // refresh row counter
        logic [9:0] refTimer; // self refresh pacing
        logic refPulse;
        logic drive;
        logic [15:0] outRise;
        logic [15:0] outFall;
    } core_state_t;
    core_state_t st;
    core_state_t next_st;

    ddr_wr_if wr ();
    logic [2:0] burstPairs;
    logic interleaved;
    logic modeValid;
    logic mrsLoad; // mode load seen this cycle
    logic ckeS, csS, bsHighS, bsLowS; // synchronised pins
    logic [2:0] cmdS;
    logic [12:0] addrS;
    logic cmdValid; // chip selected and clock enabled
    logic [1:0] ptrBin; // synced pointer as binary
    logic slotReady;
    logic reqNow; // array read this cycle
    logic [3:0] lowMask; // column bits that wrap

    //////////////////////////////////////////////////////////////////////
    // sub blocks
    ddr_strobe_capture u_capture (
        .strobeClk(strobeClk),
        .rst(rst),
        .dqIn(dqIn),
        .writeByteMask(writeByteMask),
        .wr(wr.capture)
    );

    ddr_mode_regs u_mode (
        .core_clk(core_clk),
        .rst(rst),
        .loadEn(mrsLoad),
        .bankSel({bsHighS, bsLowS}),
        .addr(addrS),
        .burstPairs(burstPairs),
        .interleaved(interleaved),
        .halfLate(readHalfLate),
        .modeValid(modeValid),
        .modeReady(modeReady),
        .dllReset(dllReset),
        .dllOn(dllOn),
        .halfDrive(halfDrive)
    );

    //////////////////////////////////////////////////////////////////////
    // beat column: wrap inside the burst, or xor for interleave
    function automatic logic [8:0] beatCol(input logic [8:0] col, input logic [2:0] beat,
                                           input logic [3:0] msk, input logic inter);
        logic [8:0] m;
        logic [8:0] inc;
        m = {5'h00, msk};
        inc = col + {6'h00, beat};
        if (inter) begin
            beatCol = col ^ ({6'h00, beat} & m);
        end else begin
            beatCol = (col & ~m) | (inc & m);
        end
    endfunction

    // decoded view of the second synchroniser stage only
    assign {ckeS, csS, cmdS, bsHighS, bsLowS, addrS} = {st.pinSync[1][22:18], st.pinSync[1][17:16],
        st.pinSync[1][12:0]};
    assign cmdValid = ckeS && !csS && st.power == P_ON;
    assign mrsLoad = cmdValid && cmdS == ddr_pkg::CMD_MODE_LOAD && st.open == 4'h0 && st.burst == B_IDLE;
    assign ptrBin = {st.ptrSync[1][1], st.ptrSync[1][1] ^ st.ptrSync[1][0]};
    assign slotReady = ptrBin != st.rdPtr;
    assign lowMask = {burstPairs, 1'b0} - 4'h1;
    // array read once latency has run down and cut-off not reached
    assign reqNow = st.burst == B_READ && st.rdWait == 2'h0 && (!st.term || st.termCount > 2'h1);

    //////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_st = st;
        next_st.pinSync[0] = {cke, csN, rasN, casN, weN, bankSelectHigh, bankSelectLow, 3'h0, addr};
        next_st.pinSync[1] = st.pinSync[0];
        next_st.ptrSync[0] = wr.ptrGray;
        next_st.ptrSync[1] = st.ptrSync[0];
        next_st.prevCke = ckeS;
        next_st.refPulse = 1'b0;
        next_st.drive = reqNow;
        // read pipe: array answers in the request cycle, drive next
        if (reqNow) begin
            next_st.outRise = arrayReadRise;
            next_st.outFall = arrayReadFall;
        end
        // read burst sequencing
        if (st.burst == B_READ) begin
            if (st.rdWait != 2'h0) begin
                next_st.rdWait = st.rdWait - 2'h1;
            end
            if (st.term) begin
                next_st.termCount = st.termCount - 2'h1;
            end
            if (reqNow) begin
                next_st.pairIdx = st.pairIdx + 2'h1;
                next_st.pairsLeft = st.pairsLeft - 3'h1;
            end
            if ((reqNow && st.pairsLeft == 3'h1) || (st.term && st.termCount <= 2'h1)) begin
                next_st.burst = B_IDLE;
                if (st.bAuto && !st.term) begin
                    next_st.open[st.bBank] = 1'b0;
                end
            end
        end
        // write drain: one captured pair per cycle
        if (slotReady) begin
            next_st.rdPtr = st.rdPtr + 2'h1;
            if (st.burst == B_WRITE) begin
                next_st.pairIdx = st.pairIdx + 2'h1;
                next_st.pairsLeft = st.pairsLeft - 3'h1;
                if (st.pairsLeft == 3'h1) begin
                    next_st.burst = B_IDLE;
                    if (st.bAuto) begin
                        next_st.open[st.bBank] = 1'b0;
                    end
                end
            end
        end
        // commands
        if (cmdValid) begin
            unique case (cmdS)
                ddr_pkg::CMD_ACTIVATE: begin
                    next_st.open[{bsHighS, bsLowS}] = 1'b1;
                end
                ddr_pkg::CMD_READ, ddr_pkg::CMD_WRITE: begin
                    // auto precharge bursts run to completion
                    if (!(st.burst != B_IDLE && st.bAuto)) begin
                        next_st.burst = cmdS == ddr_pkg::CMD_READ ? B_READ : B_WRITE;
                        next_st.bBank = {bsHighS, bsLowS};
                        next_st.bCol = addrS[8:0];
                        next_st.bAuto = addrS[ddr_pkg::AUTO_PRE_BIT];
                        next_st.pairsLeft = burstPairs;
                        next_st.pairIdx = 2'h0;
                        next_st.rdWait = ddr_pkg::READ_LATENCY_CYCLES - 2'h1;
                        next_st.term = 1'b0;
                        // stale pairs from an earlier burst are dropped
                        next_st.rdPtr = ptrBin;
                    end
                end
                ddr_pkg::CMD_PRECHARGE: begin
                    if (addrS[ddr_pkg::AUTO_PRE_BIT]) begin
                        next_st.open = 4'h0;
                    end else begin
                        next_st.open[{bsHighS, bsLowS}] = 1'b0;
                    end
                    if (addrS[ddr_pkg::AUTO_PRE_BIT] || {bsHighS, bsLowS} == st.bBank) begin
                        if (st.burst == B_READ && !st.term) begin
                            next_st.term = 1'b1;
                            next_st.termCount = ddr_pkg::READ_LATENCY_CYCLES;
                        end else if (st.burst == B_WRITE) begin
                            // input path reset now; later pairs discarded
                            next_st.burst = B_IDLE;
                            next_st.rdPtr = ptrBin;
                        end
                    end
                end
                ddr_pkg::CMD_BURST_STOP: begin
                    // writes ignore it
                    if (st.burst == B_READ && !st.term) begin
                        next_st.term = 1'b1;
                        next_st.termCount = ddr_pkg::READ_LATENCY_CYCLES;
                    end
                end
                ddr_pkg::CMD_REFRESH: begin
                    next_st.row = st.row + 13'h0001;
                    next_st.refPulse = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // power transitions on clock enable
        unique case (st.power)
            P_ON: begin
                if (st.prevCke && !ckeS && !csS && cmdS == ddr_pkg::CMD_REFRESH && st.open == 4'h0
                    && st.burst == B_IDLE) begin
                    next_st.power = P_SELF;
                    next_st.refTimer = 10'h000;
                end else if (st.prevCke && !ckeS && st.burst == B_IDLE) begin
                    next_st.power = P_DOWN;
                end
            end
            P_DOWN: begin
                if (ckeS) begin
                    next_st.power = P_ON;
                end
            end
            P_SELF: begin
                // internal refresh paced at the distributed interval
                if (st.refTimer == 10'(REFRESH_CYCLES - 1)) begin
                    next_st.refTimer = 10'h000;
                    next_st.row = st.row + 13'h0001;
                    next_st.refPulse = 1'b1;
                end else begin
                    next_st.refTimer = st.refTimer + 10'h001;
                end
                if (ckeS) begin
                    next_st.power = P_ON;
                end
            end
            default: begin
                next_st.power = P_ON;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
            st.burst <= B_IDLE;
            st.power <= P_ON;
        end else begin
            st <= next_st;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // outputs
    assign readRiseWord = st.outRise;
    assign readFallWord = st.outFall;
    assign dqDriveEn_n = !st.drive;
    assign arrayReadEn = reqNow;
    assign arrayWriteEn = slotReady && st.burst == B_WRITE;
    assign arrayBank = st.bBank;
    assign arrayColRise = beatCol(st.bCol, {st.pairIdx, 1'b0}, lowMask, interleaved);
    assign arrayColFall = beatCol(st.bCol, {st.pairIdx, 1'b1}, lowMask, interleaved);
    assign arrayWriteRise = wr.slotRise[st.rdPtr];
    assign arrayWriteFall = wr.slotFall[st.rdPtr];
    assign arrayWriteMask = wr.slotMask[st.rdPtr];
    assign arrayRefresh = st.refPulse;
    assign refreshRow = st.row;
    assign bankOpen = st.open;
    assign selfRefreshOn = st.power == P_SELF;
    assign powerDownOn = st.power == P_DOWN;
    assign ioBuffersOn = st.power == P_ON;
endmodule

/* File: ddr_pkg.sv */
package ddr_pkg;
    // clock and refresh timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int REFRESH_INTERVAL_NS = 7800;
    // longest interval, so round down
    localparam int REFRESH_INTERVAL_CYCLES = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
    localparam int ROW_COUNT = 8192;
    localparam int ROW_BITS = 13;
    localparam int REFRESH_WINDOW_MS = 64;

    // command codes as {row strobe, column strobe, write enable}, active low
    localparam logic [2:0] CMD_MODE_LOAD = 3'h0;
    localparam logic [2:0] CMD_REFRESH = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_ACTIVATE = 3'h3;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_BURST_STOP = 3'h6;
    localparam logic [2:0] CMD_NOP = 3'h7;

    // address field positions
    localparam int AUTO_PRE_BIT = 10;
    localparam int BL_LSB = 0;
    localparam int ORDER_BIT = 3;
    localparam int CL_LSB = 4;
    localparam int TEST_BIT = 7;
    localparam int DLL_RESET_BIT = 8;
    localparam int RESERVED_LSB = 9;
    localparam int EXT_DLL_OFF_BIT = 0;
    localparam int EXT_HALF_DRIVE_BIT = 1;

    // field codes
    localparam logic [2:0] BL_CODE_2 = 3'h1;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    localparam logic [2:0] CL_CODE_2 = 3'h2;
    localparam logic [2:0] CL_CODE_25 = 3'h6;
    localparam logic [1:0] READ_LATENCY_CYCLES = 2'h2;
    localparam logic [1:0] BS_REGULAR = 2'h0;
    localparam logic [1:0] BS_EXTENDED = 2'h1;
    localparam logic [12:0] MODE_RESET_VALUE = 13'h0000;
endpackage

/* File: ddr_wr_if.sv */
`timescale 1ns/100ps
// write pairs captured on the strobe, handed to the core clock
interface ddr_wr_if;
    logic [1:0] ptrGray; // gray write pointer, strobe domain
    logic [15:0] slotRise [4]; // word taken on rising strobe
    logic [15:0] slotFall [4]; // word taken on falling strobe
    logic [1:0] slotMask [4]; // {rise mask, fall mask}
    modport capture (output ptrGray, output slotRise, output slotFall, output slotMask);
    modport core (input ptrGray, input slotRise, input slotFall, input slotMask);
endinterface

/* File: ddr_strobe_capture.sv */
`timescale 1ns/100ps
// write data taken on both strobe edges; runs on the strobe clock
module ddr_strobe_capture (
    input wire logic strobeClk,
    input wire logic rst,
    input wire logic [15:0] dqIn,
    input wire logic writeByteMask,
    ddr_wr_if.capture wr
);
    typedef struct packed {
        logic [1:0] rstSync; // reset brought into strobe domain
        logic [1:0] ptr; // binary slot pointer
    } cap_state_t;
    cap_state_t st;
    cap_state_t next_st;
    logic [15:0] riseWord; // held from the rising edge
    logic riseMask;

    //////////////////////////////////////////////////////////////////////
    // rising edge half of each pair
    always_ff @(posedge strobeClk) begin
        riseWord <= dqIn;
        riseMask <= writeByteMask;
    end

    // pointer advance; reset seen only while the strobe toggles
    always_comb begin
        next_st = st;
        next_st.rstSync = {st.rstSync[0], rst};
        next_st.ptr = st.rstSync[1] ? 2'h0 : st.ptr + 2'h1;
    end

    //////////////////////////////////////////////////////////////////////
    // falling edge completes the pair and publishes it
    always_ff @(negedge strobeClk) begin
        st <= next_st;
        if (!st.rstSync[1]) begin
            wr.slotRise[st.ptr] <= riseWord;
            wr.slotFall[st.ptr] <= dqIn;
            wr.slotMask[st.ptr] <= {riseMask, writeByteMask};
        end
    end

    // gray code so the core never sees a torn pointer
    assign wr.ptrGray = st.ptr ^ {1'b0, st.ptr[1]};
endmodule

/* File: ddr_mode_regs.sv */
`timescale 1ns/100ps
// mode and extended mode words with decoded fields
module ddr_mode_regs (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic loadEn,
    input wire logic [1:0] bankSel,
    input wire logic [12:0] addr,
    output logic [2:0] burstPairs,
    output logic interleaved,
    output logic halfLate,
    output logic modeValid,
    output logic modeReady,
    output logic dllReset,
    output logic dllOn,
    output logic halfDrive
);
    typedef struct packed {
        logic [12:0] opWord; // operating_mode_word
        logic [12:0] extWord; // extended_operating_mode_word
        logic opDone;
        logic extDone;
        logic dllResetPulse;
    } mode_state_t;
    mode_state_t st;
    mode_state_t next_st;
    logic [2:0] blCode;
    logic [2:0] clCode;

    // load picks target by bank select; high select reserved and ignored
    always_comb begin
        next_st = st;
        next_st.dllResetPulse = 1'b0;
        if (loadEn && bankSel == ddr_pkg::BS_REGULAR) begin
            next_st.opWord = addr;
            next_st.opDone = 1'b1;
            next_st.dllResetPulse = addr[ddr_pkg::DLL_RESET_BIT];
        end else if (loadEn && bankSel == ddr_pkg::BS_EXTENDED) begin
            next_st.extWord = addr;
            next_st.extDone = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '{ddr_pkg::MODE_RESET_VALUE, ddr_pkg::MODE_RESET_VALUE, 1'b0, 1'b0, 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // field decode
    assign blCode = st.opWord[ddr_pkg::BL_LSB +: 3];
    assign clCode = st.opWord[ddr_pkg::CL_LSB +: 3];
    always_comb begin
        unique case (blCode)
            ddr_pkg::BL_CODE_2: burstPairs = 3'h1;
            ddr_pkg::BL_CODE_4: burstPairs = 3'h2;
            ddr_pkg::BL_CODE_8: burstPairs = 3'h4;
            default: burstPairs = 3'h1; // reserved: shortest burst
        endcase
    end
    assign interleaved = st.opWord[ddr_pkg::ORDER_BIT];
    assign halfLate = (clCode == ddr_pkg::CL_CODE_25);
    // reserved codes and test mode mark the word unusable
    assign modeValid = (blCode == ddr_pkg::BL_CODE_2 || blCode == ddr_pkg::BL_CODE_4 || blCode == ddr_pkg::BL_CODE_8)
        && (clCode == ddr_pkg::CL_CODE_2 || clCode == ddr_pkg::CL_CODE_25)
        && !st.opWord[ddr_pkg::TEST_BIT] && st.opWord[12:ddr_pkg::RESERVED_LSB] == 4'h0;
    assign modeReady = st.opDone && st.extDone;
    assign dllReset = st.dllResetPulse;
    assign dllOn = !st.extWord[ddr_pkg::EXT_DLL_OFF_BIT];
    assign halfDrive = st.extWord[ddr_pkg::EXT_HALF_DRIVE_BIT];
endmodule

/* File: ddr_bank_ctrl_assertions.sv */
`timescale 1ns/100ps
// watches the command core from its top-level pins only
module ddr_bank_ctrl_assertions #(
    parameter int REFRESH_CYCLES = 780
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cke,
    input wire logic arrayReadEn,
    input wire logic dqDriveEn_n,
    input wire logic [3:0] bankOpen,
    input wire logic selfRefreshOn,
    input wire logic powerDownOn,
    input wire logic ioBuffersOn,
    input wire logic modeReady,
    input wire logic dllReset
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // read pad drive follows array requests one cycle behind
    a_read_drive_start: assert property ($rose(arrayReadEn) |=> !dqDriveEn_n)
        else $error("read drive late");
    a_drive_needs_read: assert property ($fell(dqDriveEn_n) |-> $past(arrayReadEn))
        else $error("drive without request");
    // two quiet cycles mean the pad is released, also after a cut
    a_drive_ends: assert property (!arrayReadEn && !$past(arrayReadEn) |-> dqDriveEn_n)
        else $error("drive not released");
    // low power states keep buffers off
    a_self_ref_io: assert property (selfRefreshOn |-> !ioBuffersOn)
        else $error("buffers on in self refresh");
    a_pdown_io: assert property (powerDownOn |-> !ioBuffersOn)
        else $error("buffers on in power down");
    a_self_ref_idle: assert property ($rose(selfRefreshOn) |-> bankOpen == 4'h0)
        else $error("self refresh with open bank");
    // three low samples rule out an exit still in the synchroniser
    a_self_ref_hold: assert property (selfRefreshOn && !cke && !$past(cke) && !$past(cke, 2)
        |=> selfRefreshOn) else $error("self refresh left with clock enable low");
    a_mode_ready_keep: assert property (modeReady |=> modeReady)
        else $error("mode ready dropped");
    a_dll_reset_pulse: assert property (dllReset |=> !dllReset)
        else $error("dll reset longer than one cycle");
endmodule
bind ddr_bank_ctrl ddr_bank_ctrl_assertions #(.REFRESH_CYCLES(REFRESH_CYCLES)) i_chk (.core_clk, .rst, .cke,
    .arrayReadEn, .dqDriveEn_n, .bankOpen, .selfRefreshOn, .powerDownOn, .ioBuffersOn, .modeReady, .dllReset);

/* File: ddr_wr_partner.sv */
`timescale 1ns/100ps
// controller side of the write link; strobe stands still between bursts
module ddr_wr_partner (
    output logic strobeClk,
    output logic [15:0] dqIn,
    output logic writeByteMask
);
    initial begin
        strobeClk = 1'b0;
        dqIn = 16'hFFFF;
        writeByteMask = 1'b1;
    end
    // one word per strobe edge, set 3 ns ahead so the edge is centred
    task automatic burst(input int pairs, input logic [15:0] w, input logic m);
        for (int i = 0; i < 2 * pairs; i++) begin
            dqIn = w + 16'(i);
            writeByteMask = m;
            #3 strobeClk = !strobeClk;
            #3;
        end
        // released lines must not look like the last word
        dqIn = ~dqIn;
        writeByteMask = 1'b1;
    endtask
endmodule

/* File: ddr_bank_ctrl_tb.sv */
`timescale 1ns/100ps
module ddr_bank_ctrl_tb;
    logic core_clk = 0, rst = 1, cke = 0, csN = 1, rasN = 1, casN = 1, weN = 1;
    logic bankSelectHigh = 0, bankSelectLow = 0, strobeClk, writeByteMask;
    logic [12:0] addr = 13'h0000, refreshRow;
    logic [15:0] dqIn, arrayReadRise, arrayReadFall, readRiseWord, readFallWord, arrayWriteRise, arrayWriteFall;
    logic [8:0] arrayColRise, arrayColFall, c;
    logic [3:0] bankOpen;
    logic [2:0] cl;
    logic [2:0] stops [2] = '{ddr_pkg::CMD_PRECHARGE, ddr_pkg::CMD_BURST_STOP};
    logic [1:0] arrayBank, arrayWriteMask, b;
    logic dqDriveEn_n, readHalfLate, arrayReadEn, arrayWriteEn, arrayRefresh, selfRefreshOn, powerDownOn;
    logic ioBuffersOn, dllOn, halfDrive, modeReady, dllReset;
    int num_errors = 0, check_count = 0;
    // array model: each word carries its own bank and column
    assign arrayReadRise = {5'h00, arrayBank, arrayColRise};
    assign arrayReadFall = {5'h00, arrayBank, arrayColFall};
    ddr_bank_ctrl #(.REFRESH_CYCLES(8)) i_dut (.*);
    ddr_wr_partner i_partner (.strobeClk, .dqIn, .writeByteMask);
    initial forever #5 core_clk = !core_clk;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one command cycle, then a no-op
    task automatic cmd(input logic [2:0] k, input logic [1:0] bk, input logic [12:0] a);
        @(posedge core_clk);
        {rasN, casN, weN} <= k;
        {bankSelectHigh, bankSelectLow} <= bk;
        addr <= a;
        @(posedge core_clk);
        {rasN, casN, weN} <= ddr_pkg::CMD_NOP;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // column of beat i: sequential wraps in the low bits, interleave xors
    function automatic logic [8:0] bcol(input logic [8:0] s, input int n, input int i, input logic il);
        logic [8:0] m;
        m = 9'(n - 1);
        return il ? s ^ 9'(i) : (s & ~m) | ((s + 9'(i)) & m);
    endfunction
    task automatic rd(input logic [1:0] bk, input logic [8:0] s, input int n, input logic il, input logic ap,
                      input logic [2:0] stop);
        int k = 0;
        cmd(ddr_pkg::CMD_READ, bk, {2'h0, ap, 1'b0, s});
        if (stop != ddr_pkg::CMD_NOP) cmd(stop, bk, 13'h0000);
        repeat (14) begin
            @(posedge core_clk);
            #1;
            if (dqDriveEn_n === 1'b0) begin
                chk(readRiseWord, {5'h00, bk, bcol(s, n, 2 * k, il)}, "rise");
                chk(readFallWord, {5'h00, bk, bcol(s, n, 2 * k + 1, il)}, "fall");
                k++;
            end
        end
        chk(16'(k == n / 2), 16'(stop == ddr_pkg::CMD_NOP), "pairs");
    endtask
    // write with auto precharge; the bank must close by itself
    task automatic wr(input logic [1:0] bk, input logic [8:0] s, input int n, input logic il, input logic [15:0] w);
        int k = 0;
        cmd(ddr_pkg::CMD_WRITE, bk, {4'h2, s});
        fork
            i_partner.burst(n / 2, w, 1'b0);
            repeat (20) begin
                @(posedge core_clk);
                #1;
                if (arrayWriteEn === 1'b1) begin
                    chk(arrayWriteRise, w + 16'(2 * k), "wdata");
                    chk(arrayWriteFall, w + 16'(2 * k + 1), "wfall");
                    chk({arrayWriteMask, 5'h00, arrayColFall}, {7'h00, bcol(s, n, 2 * k + 1, il)}, "wcol");
                    k++;
                end
            end
        join
        chk(16'(k), 16'(n / 2), "wpairs");
        chk({12'h000, bankOpen}, 16'h0000, "wclose");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(42151));
        fork
            i_partner.burst(5, 16'h0000, 1'b1); // strobe runs past release so its reset clears
        join_none
        idle(3);
        rst <= 1'b0;
        cke <= 1'b1;
        csN <= 1'b0;
        cmd(ddr_pkg::CMD_MODE_LOAD, ddr_pkg::BS_EXTENDED, 13'h0002);
        cmd(ddr_pkg::CMD_MODE_LOAD, 2'h2, 13'h0001);
        idle(4);
        chk({14'h0000, dllOn, halfDrive}, 16'h0003, "ext");
        for (int bl = 1; bl < 4; bl++) begin
            for (int il = 0; il < 2; il++) begin
                cl = ($urandom % 2) ? ddr_pkg::CL_CODE_25 : ddr_pkg::CL_CODE_2;
                b = 2'($urandom);
                c = 9'($urandom);
                cmd(ddr_pkg::CMD_MODE_LOAD, ddr_pkg::BS_REGULAR, {4'h0, 2'h2, cl, 1'(il), 3'(bl)});
                idle(4);
                chk({14'h0000, modeReady, readHalfLate}, {15'h0001, cl == ddr_pkg::CL_CODE_25}, "cl");
                cmd(ddr_pkg::CMD_ACTIVATE, b, 13'h0000);
                idle(2);
                rd(b, c, 1 << bl, 1'(il), 1'b1, ddr_pkg::CMD_NOP);
                chk({12'h000, bankOpen}, 16'h0000, "rclose");
                cmd(ddr_pkg::CMD_ACTIVATE, b, 13'h0000);
                idle(2);
                wr(b, c, 1 << bl, 1'(il), 16'($urandom));
            end
        end
        foreach (stops[i]) begin
            cmd(ddr_pkg::CMD_ACTIVATE, 2'h3, 13'h0000);
            idle(2);
            rd(2'h3, 9'h005, 8, 1'b1, 1'b0, stops[i]);
            cmd(ddr_pkg::CMD_PRECHARGE, 2'h1, 13'h0400);
        end
        cmd(ddr_pkg::CMD_ACTIVATE, 2'h0, 13'h0000);
        cmd(ddr_pkg::CMD_ACTIVATE, 2'h2, 13'h0000);
        cmd(ddr_pkg::CMD_PRECHARGE, 2'h0, 13'h0000);
        idle(4);
        chk({12'h000, bankOpen}, 16'h0004, "pre1");
        cmd(ddr_pkg::CMD_PRECHARGE, 2'h1, 13'h0400);
        idle(4);
        chk({12'h000, bankOpen}, 16'h0000, "preall");
        cmd(ddr_pkg::CMD_REFRESH, 2'h0, 13'h0000);
        cke <= 1'b0;
        idle(5);
        chk({14'h0000, powerDownOn, ioBuffersOn}, 16'h0002, "pdown");
        cke <= 1'b1;
        idle(5);
        @(posedge core_clk);
        cke <= 1'b0;
        {rasN, casN, weN} <= ddr_pkg::CMD_REFRESH;
        @(posedge core_clk);
        {rasN, casN, weN} <= ddr_pkg::CMD_NOP;
        idle(18); // long enough for two paced internal refreshes
        chk({14'h0000, selfRefreshOn, ioBuffersOn}, 16'h0002, "sref");
        cke <= 1'b1;
        idle(30);
        chk({selfRefreshOn, powerDownOn, ioBuffersOn, refreshRow}, {3'h1, 13'h0003}, "wake");
        test_done();
    end
    // hang guard, well past the run's length
    initial begin
        #200000;
        num_errors++;
        test_done();
    end
endmodule
